// ---- pkg/trf_pkg.sv ----
// constants and types shared by the temperature readout and fan code block
// Functional notes
// - each on-chip sensor result is shown as an 8-bit signed two's-complement value, one degree per bit.
// - the encoding spans -128 to +127, with -128 as 80h, -1 as FFh, zero as 00h and +127 as 7Fh.
// - remote diode results use the same 8-bit two's-complement format as on-chip results.
// - sixteen successive remote measurement cycles are averaged into one remote result.
// - one complete remote measurement with its averaging takes about 9.6 ms.
// - during each remote measurement the excitation alternates between base current and N times that current.
// - power-on reset clears the fan code register to 00h so the fan output starts at minimum.
// - the fan output is driven by an unsigned 8-bit code, zero lowest, larger codes higher.
// - after reset the two pins next to the remote inputs act as over-temperature indication outputs.
// - a fan gating output switches the fan on or off independently of the applied fan code.
// - the fan code sits in a dedicated register written from the management side.
// - while over-temperature indication is active the applied fan code is forced to FFh.
package trf_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam real REMOTE_MEAS_MS = 9.6;
  localparam int unsigned REMOTE_MEAS_CYC = int'(REMOTE_MEAS_MS * 1.0e-3 * CLK_HZ);
  localparam int unsigned AVG_COUNT = 16;
  localparam int unsigned AVG_SHIFT = 4;
  localparam int unsigned CYCLE_SLOT_CYC = REMOTE_MEAS_CYC / AVG_COUNT;
  localparam int unsigned HALF_SLOT_CYC = CYCLE_SLOT_CYC / 2;
  localparam logic [7:0] FAN_CODE_RESET = 8'h00;
  localparam logic [7:0] FAN_CODE_FULL = 8'hFF;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic PIN_MODE_OVERTEMP = 1'b0;
  typedef enum logic [1:0] {TRF_IDLE, TRF_LOW_I, TRF_HIGH_I, TRF_DONE} trf_rstate_t;
endpackage

// ---- pkg/trf_sample_if.sv ----
// carrier for one temperature sample between the sequencer and the averager
`timescale 1ns/1ps
interface trf_sample_if;
  logic valid;
  logic signed [7:0] sample;
  logic clear;
  logic done;
  logic signed [7:0] result;
  modport src (output valid, output sample, output clear, input done, input result);
  modport sink (input valid, input sample, input clear, output done, output result);
endinterface

// ---- hw/trf_averager.sv ----
// sixteen-sample averager for remote channel readings
`timescale 1ns/1ps
module trf_averager
  import trf_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  trf_sample_if.sink smp
);
  logic signed [11:0] acc_q, acc_d;
  logic [3:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic signed [7:0] res_q, res_d;
  logic signed [11:0] sum;

  always_comb begin
    sum = acc_q + 12'(smp.sample);
    acc_d = acc_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    res_d = res_q;
    if (smp.clear) begin
      acc_d = '0;
      cnt_d = '0;
    end else if (smp.valid) begin
      // averaging of sixteen cycles, arithmetic shift keeps sign
      if (cnt_q == 4'(AVG_COUNT - 1)) begin
        res_d = 8'(sum >>> AVG_SHIFT);
        done_d = 1'b1;
        acc_d = '0;
        cnt_d = '0;
      end else begin
        acc_d = sum;
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_q <= '0;
      cnt_q <= '0;
      done_q <= 1'b0;
      res_q <= TEMP_RESET;
    end else begin
      acc_q <= acc_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
      res_q <= res_d;
    end
  end

  assign smp.done = done_q;
  assign smp.result = res_q;
endmodule

// ---- hw/trf_fan_out.sv ----
// fan code selection and gating
`timescale 1ns/1ps
module trf_fan_out
  import trf_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] code_in,
  input wire logic overtemp_in,
  input wire logic fan_enable_in,
  output logic [7:0] level_out,
  output logic fan_on_out
);
  logic [7:0] level_q, level_d;
  logic fan_on_q, fan_on_d;

  always_comb begin
    // override wins over programmed code; register keeps its value
    level_d = overtemp_in ? FAN_CODE_FULL : code_in;
    // gate independent of code, but never off while forced full
    fan_on_d = fan_enable_in | overtemp_in;
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      level_q <= FAN_CODE_RESET;
      fan_on_q <= 1'b0;
    end else begin
      level_q <= level_d;
      fan_on_q <= fan_on_d;
    end
  end

  assign level_out = level_q;
  assign fan_on_out = fan_on_q;
endmodule

// ---- hw/trf_top.sv ----
// temperature readout, remote averaging sequencer and fan code holder
`timescale 1ns/1ps
module trf_top
  import trf_pkg::*;
#(
  parameter int unsigned SLOT_CYC = CYCLE_SLOT_CYC
)
(
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic local_valid_in,
  input wire logic [7:0] local_code_in,
  input wire logic remote_start_in,
  input wire logic remote_valid_in,
  input wire logic [7:0] remote_code_in,
  input wire logic fan_code_we_in,
  input wire logic [7:0] fan_code_in,
  input wire logic fan_enable_in,
  input wire logic overtemp_in,
  input wire logic pin_mode_we_in,
  input wire logic pin_mode_in,
  output logic signed [7:0] local_temp_out,
  output logic signed [7:0] remote_temp_out,
  output logic remote_done_out,
  output logic remote_busy_out,
  output logic excite_high_out,
  output logic sample_strobe_out,
  output logic [7:0] fan_code_out,
  output logic [7:0] fan_level_output_out,
  output logic fan_on_out,
  output logic overtemp_indication_a_out,
  output logic overtemp_indication_a_oe_n_out,
  output logic overtemp_indication_b_out,
  output logic overtemp_indication_b_oe_n_out,
  output logic pin_mode_out
);
  trf_sample_if smp();

  trf_rstate_t st_q, st_d;
  logic [31:0] tmr_q, tmr_d;
  logic [3:0] cyc_q, cyc_d;
  logic signed [7:0] local_q, local_d;
  logic signed [7:0] remote_q, remote_d;
  logic done_q, done_d;
  logic got_q, got_d;
  logic [7:0] fan_code_q, fan_code_d;
  logic pin_mode_q, pin_mode_d;
  logic slot_end, half_end;

  assign half_end = (tmr_q == SLOT_CYC / 2 - 1);
  assign slot_end = (tmr_q == SLOT_CYC - 1);

  // sequencer: sixteen slots, each half low then half high current
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    cyc_d = cyc_q;
    // averager result may land before the last slot ends, so remember it
    got_d = got_q | smp.done;
    smp.clear = 1'b0;
    case (st_q)
      TRF_IDLE: begin
        if (remote_start_in) begin
          st_d = TRF_LOW_I;
          tmr_d = '0;
          cyc_d = '0;
          got_d = 1'b0;
          smp.clear = 1'b1;
        end
      end
      TRF_LOW_I: begin
        tmr_d = tmr_q + 32'd1;
        if (half_end) begin
          st_d = TRF_HIGH_I;
        end
      end
      TRF_HIGH_I: begin
        tmr_d = tmr_q + 32'd1;
        if (slot_end) begin
          // slot length sums to the nominal 9.6 ms over sixteen slots
          tmr_d = '0;
          if (cyc_q == 4'(AVG_COUNT - 1)) begin
            st_d = TRF_DONE;
          end else begin
            cyc_d = cyc_q + 4'h1;
            st_d = TRF_LOW_I;
          end
        end
      end
      TRF_DONE: begin
        if (got_q || smp.done) begin
          st_d = TRF_IDLE;
        end
      end
      default: begin
        st_d = TRF_IDLE;
      end
    endcase
  end

  // one converted result per slot, taken only while high current phase runs
  assign smp.valid = remote_valid_in && (st_q == TRF_HIGH_I);
  assign smp.sample = remote_code_in;

  trf_averager u_avg (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .smp(smp)
  );

  always_comb begin
    // whole-byte loads only when a result completes or a write strobe is set
    local_d = local_valid_in ? local_code_in : local_q;
    remote_d = smp.done ? smp.result : remote_q;
    done_d = smp.done;
    fan_code_d = fan_code_we_in ? fan_code_in : fan_code_q;
    pin_mode_d = pin_mode_we_in ? pin_mode_in : pin_mode_q;
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= TRF_IDLE;
      tmr_q <= '0;
      cyc_q <= '0;
      local_q <= TEMP_RESET;
      remote_q <= TEMP_RESET;
      done_q <= 1'b0;
      got_q <= 1'b0;
      fan_code_q <= FAN_CODE_RESET;
      pin_mode_q <= PIN_MODE_OVERTEMP;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      cyc_q <= cyc_d;
      local_q <= local_d;
      remote_q <= remote_d;
      done_q <= done_d;
      got_q <= got_d;
      fan_code_q <= fan_code_d;
      pin_mode_q <= pin_mode_d;
    end
  end

  trf_fan_out u_fan (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .code_in(fan_code_q),
    .overtemp_in(overtemp_in),
    .fan_enable_in(fan_enable_in),
    .level_out(fan_level_output_out),
    .fan_on_out(fan_on_out)
  );

  // signed byte passes unchanged: -128 is 80h, +127 is 7Fh
  assign local_temp_out = local_q;
  assign remote_temp_out = remote_q;
  assign remote_done_out = done_q;
  assign remote_busy_out = (st_q != TRF_IDLE);
  assign excite_high_out = (st_q == TRF_HIGH_I);
  assign sample_strobe_out = smp.valid;
  assign fan_code_out = fan_code_q;
  assign pin_mode_out = pin_mode_q;
  // open drain: pull low while indication active and pin in over-temp mode
  assign overtemp_indication_a_out = 1'b0;
  assign overtemp_indication_b_out = 1'b0;
  assign overtemp_indication_a_oe_n_out = ~(overtemp_in && pin_mode_q == PIN_MODE_OVERTEMP);
  assign overtemp_indication_b_oe_n_out = ~(overtemp_in && pin_mode_q == PIN_MODE_OVERTEMP);
endmodule

// ---- tb/trf_top_sva.sv ----
// port-level assertions for the readout and fan code block
`timescale 1ns/1ps
module trf_top_sva (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic local_valid_in,
  input wire logic [7:0] local_code_in,
  input wire logic fan_code_we_in,
  input wire logic [7:0] fan_code_in,
  input wire logic fan_enable_in,
  input wire logic overtemp_in,
  input wire logic signed [7:0] local_temp_out,
  input wire logic signed [7:0] remote_temp_out,
  input wire logic remote_done_out,
  input wire logic excite_high_out,
  input wire logic sample_strobe_out,
  input wire logic [7:0] fan_code_out,
  input wire logic [7:0] fan_level_output_out,
  input wire logic fan_on_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  AST_FAN_RST: assert property ($rose(reset_n_in) |-> fan_code_out == 8'h00) else $error("fan code not cleared");
  AST_FAN_WR: assert property (fan_code_we_in |=> fan_code_out == $past(fan_code_in)) else $error("fan write lost");
  AST_FAN_LVL: assert property (!overtemp_in |=> fan_level_output_out == $past(fan_code_out)) else $error("fan level");
  AST_OT_FULL: assert property (overtemp_in |=> fan_level_output_out == 8'hFF) else $error("level not full");
  AST_GATE: assert property ($past(reset_n_in) |-> fan_on_out == $past(fan_enable_in | overtemp_in)) else $error("gate");
  AST_LOCAL: assert property (local_valid_in |=> local_temp_out == $past(local_code_in)) else $error("local value");
  AST_HOLD: assert property (!remote_done_out |-> $stable(remote_temp_out)) else $error("remote moved");
  AST_STROBE: assert property (sample_strobe_out |-> excite_high_out) else $error("sample at low current");
  AST_DONE_ONE: assert property (remote_done_out |=> !remote_done_out) else $error("done too long");
endmodule
bind trf_top trf_top_sva i_sva (.core_clk_in, .reset_n_in, .local_valid_in, .local_code_in, .fan_code_we_in,
  .fan_code_in, .fan_enable_in, .overtemp_in, .local_temp_out, .remote_temp_out, .remote_done_out,
  .excite_high_out, .sample_strobe_out, .fan_code_out, .fan_level_output_out, .fan_on_out);

// ---- tb/trf_diode_model.sv ----
// remote diode model: one reading per high-current phase
`timescale 1ns/1ps
module trf_diode_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic excite_high_in,
  input wire logic [7:0] base_in,
  output logic valid_out,
  output logic [7:0] code_out
);
  logic sent_q;
  logic odd_q;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sent_q <= 1'b0;
      odd_q <= 1'b0;
      valid_out <= 1'b0;
      code_out <= 8'h00;
    end else if (excite_high_in && !sent_q) begin
      sent_q <= 1'b1;
      odd_q <= ~odd_q;
      valid_out <= 1'b1;
      // alternating lsb exposes a last-sample shortcut
      code_out <= base_in + {7'h00, odd_q};
    end else begin
      sent_q <= sent_q & excite_high_in;
      valid_out <= 1'b0;
      // stale line must not look like the last reading
      code_out <= ~code_out;
    end
  end
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the readout and fan code block
`timescale 1ns/1ps
module tb;
  logic core_clk_in = 1'b0, reset_n_in = 1'b0, local_valid_in = 1'b0, remote_start_in = 1'b0;
  logic fan_code_we_in = 1'b0, fan_enable_in = 1'b0, overtemp_in = 1'b0, pin_mode_we_in = 1'b0, pin_mode_in = 1'b0;
  logic [7:0] local_code_in = 8'h00, fan_code_in = 8'h00, base = 8'h00, v, remote_code_in, fan_code_out;
  logic [7:0] fan_level_output_out, exp_local[$], exp_remote[$];
  logic signed [7:0] local_temp_out, remote_temp_out;
  logic remote_valid_in, remote_done_out, excite_high_out, fan_on_out, lv_q, oe_a_n, oe_b_n, busy;
  logic [7:0] vals[4] = '{8'h80, 8'hFF, 8'h00, 8'h7F};
  int err_count = 0, comparisons = 0, s, n;
  always #2 core_clk_in = ~core_clk_in;
  trf_top #(.SLOT_CYC(8)) i_dut (.core_clk_in, .reset_n_in, .local_valid_in, .local_code_in, .remote_start_in,
    .remote_valid_in, .remote_code_in, .fan_code_we_in, .fan_code_in, .fan_enable_in, .overtemp_in,
    .pin_mode_we_in, .pin_mode_in, .local_temp_out, .remote_temp_out, .remote_done_out, .remote_busy_out(busy),
    .excite_high_out, .sample_strobe_out(), .fan_code_out, .fan_level_output_out, .fan_on_out,
    .overtemp_indication_a_out(), .overtemp_indication_a_oe_n_out(oe_a_n), .overtemp_indication_b_out(),
    .overtemp_indication_b_oe_n_out(oe_b_n), .pin_mode_out());
  trf_diode_model i_diode (.clk_in(core_clk_in), .reset_n_in, .excite_high_in(excite_high_out), .base_in(base),
    .valid_out(remote_valid_in), .code_out(remote_code_in));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk_in);
  endtask
  always @(posedge core_clk_in) begin
    lv_q <= local_valid_in;
    if (lv_q === 1'b1) chk(local_temp_out, exp_local.pop_front());
    if (remote_done_out === 1'b1) chk(remote_temp_out, exp_remote.pop_front());
  end
  initial begin
    tick(5000);
    err_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h4e16));
    tick(8);
    reset_n_in <= 1'b1;
    tick(1);
    #1 chk(fan_level_output_out, 8'h00);
    chk({6'h00, oe_a_n, oe_b_n}, 8'h03);
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk_in);
      v = (i < 4) ? vals[i] : 8'($urandom());
      local_valid_in <= 1'b1;
      local_code_in <= v;
      exp_local.push_back(v);
    end
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk_in);
      v = (i < 4) ? vals[i] : 8'($urandom());
      local_valid_in <= 1'b0;
      base <= v;
      // eight readings of base and eight of base plus one, floored
      s = 8 * int'($signed(v)) + 8 * int'($signed(v + 8'h01));
      exp_remote.push_back(8'(s >>> 4));
      remote_start_in <= 1'b1;
      tick(1);
      remote_start_in <= 1'b0;
      tick(20);
      chk({7'h00, busy}, 8'h01);
      remote_start_in <= 1'b1;
      tick(1);
      remote_start_in <= 1'b0;
      n = 0;
      while (remote_done_out !== 1'b1 && n < 400) begin
        tick(1);
        n++;
      end
      if (n == 400) chk(8'h00, 8'h01);
    end
    @(posedge core_clk_in);
    fan_code_we_in <= 1'b1;
    fan_code_in <= 8'h5A;
    tick(1);
    fan_code_in <= 8'hA5;
    tick(1);
    fan_code_we_in <= 1'b0;
    overtemp_in <= 1'b1;
    tick(2);
    #1 chk(fan_level_output_out, 8'hFF);
    chk({6'h00, fan_on_out, oe_a_n}, 8'h02);
    chk({7'h00, busy}, 8'h00);
    @(posedge core_clk_in);
    overtemp_in <= 1'b0;
    fan_enable_in <= 1'b1;
    tick(2);
    #1 chk(fan_level_output_out, 8'hA5);
    chk({7'h00, fan_on_out}, 8'h01);
    @(posedge core_clk_in);
    fan_enable_in <= 1'b0;
    pin_mode_we_in <= 1'b1;
    pin_mode_in <= 1'b1;
    tick(1);
    pin_mode_we_in <= 1'b0;
    overtemp_in <= 1'b1;
    tick(2);
    #1 chk({6'h00, fan_on_out, oe_a_n}, 8'h03);
    end_of_test();
  end
endmodule
